// ===== hw/dsa_pkg.sv
// Package with the map, reset values and carrier types of the DMA status and address block.
package dsa_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_CH = 8;
  localparam int CH_PER_CTRL = 4;
  localparam int NUM_CTRL = 2;
  localparam logic [2:0] CASCADE_CH = 3'h4;

  // ----------------------------------------------------------------
  // I/O port map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CHAN_ADDR [NUM_CH] = '{8'h00, 8'h02, 8'h04, 8'h06, 8'hC0, 8'hC4, 8'hC8, 8'hCC};
  localparam logic [7:0] OFS_LOWER_STATUS = 8'h08;
  localparam logic [7:0] OFS_UPPER_STATUS = 8'hD0;

  // ----------------------------------------------------------------
  // Reset values and status layout
  // ----------------------------------------------------------------
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [15:0] ADDR_STEP = 16'h0001;
  localparam int TC_LSB = 0;
  localparam int REQ_LSB = 4;

  // ----------------------------------------------------------------
  // Port decode result kinds
  // ----------------------------------------------------------------
  localparam logic [1:0] PORT_NONE = 2'h0;
  localparam logic [1:0] PORT_ADDR = 2'h1;
  localparam logic [1:0] PORT_STATUS = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dsa_io_req_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dsa_io_rsp_t;

  typedef struct packed {
    logic [NUM_CH-1:0] xfer;
    logic [NUM_CH-1:0] tc;
    logic [NUM_CH-1:0] eop;
    logic [NUM_CH-1:0] dec;
    logic [NUM_CH-1:0] autoinit;
    logic [NUM_CH-1:0] sg_load;
  } dsa_chan_ev_t;

  typedef struct packed {
    logic [NUM_CH-1:0] hw_req;
    logic [NUM_CH-1:0] sw_req;
    logic [NUM_CH-1:0] blk_tmo;
  } dsa_req_src_t;

endpackage : dsa_pkg

// ===== hw/dsa_status_addr.sv
// Status registers and base/current address registers of the two-controller, eight-channel DMA unit.
//
// Behaviour
// - Each controller has one read-only 8-bit status register at its own port.
// - Reaching terminal count sets that channel's status flag in bits 3:0.
// - Reset and every status read clear that controller's terminal-count flags.
// - Status bits 7:4 show live, unlatched pending requests per channel.
// - Request bits 4..7 map to controller channels 0..3 (upper: channels 4..7).
// - A request bit shows hardware, block timeout or software requests alike.
// - Cascade channel 4 status bits carry no meaning; they read as zero.
// - Each channel holds a 16-bit current address, the low bits of the address.
// - After each transfer the current address steps up or down as configured.
// - Address ports are byte-serial: low byte first after pointer clear, reads too.
// - A host write loads the byte into both base and current registers.
// - Base is never readable; address port reads return current address bytes.
// - Autoinitialize copies base into current only on terminal count or end of process.
// - Scatter-gather loads the reserve buffer address into base during transfer.
// - Address joins low page for 24 bits and high page too for 32 bits.
// - Reset or master clear zeroes base and current; status resets to zero.
// - Terminal count arrives as a per-channel event input; it sets flag, autoinit.
module dsa_status_addr (
  input wire logic I_REF_CLK,
  input wire logic I_RSTN,
  input wire dsa_pkg::dsa_io_req_t I_IO_REQ,
  output dsa_pkg::dsa_io_rsp_t O_IO_RSP,
  input wire logic [dsa_pkg::NUM_CTRL-1:0] I_CLR_BPTR,
  input wire logic [dsa_pkg::NUM_CTRL-1:0] I_MASTER_CLR,
  input wire dsa_pkg::dsa_chan_ev_t I_CHAN_EV,
  input wire dsa_pkg::dsa_req_src_t I_REQ_SRC,
  input wire logic [15:0] I_SG_ADDR,
  input wire logic [2:0] I_ACT_CH,
  input wire logic [7:0] I_LOW_PAGE,
  input wire logic [7:0] I_HIGH_PAGE,
  output logic [23:0] O_ADDR24,
  output logic [31:0] O_ADDR32,
  output logic [dsa_pkg::NUM_CH-1:0] O_TC_FLAGS
);
  import dsa_pkg::*;

  // ----------------------------------------------------------------
  // Port decode
  // ----------------------------------------------------------------
  function automatic logic [4:0] port_decode(input logic [7:0] a);
    logic [4:0] r;
    r = {PORT_NONE, 3'h0};
    if (a == OFS_LOWER_STATUS) begin
      r = {PORT_STATUS, 3'h0};
    end else if (a == OFS_UPPER_STATUS) begin
      r = {PORT_STATUS, 3'h4};
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (a == OFS_CHAN_ADDR[i]) begin
          r = {PORT_ADDR, 3'(i)};
        end
      end
    end
    return r;
  endfunction : port_decode

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [15:0] cur [NUM_CH];
  logic [15:0] base [NUM_CH];
  logic [NUM_CTRL-1:0] bptr;
  logic [NUM_CH-1:0] tc_flag;
  logic [NUM_CH-1:0] hw_req_meta;
  logic [NUM_CH-1:0] hw_req_sync;
  dsa_io_rsp_t rsp;
  logic [31:0] addr32;

  logic [15:0] next_cur [NUM_CH];
  logic [15:0] next_base [NUM_CH];
  logic [NUM_CTRL-1:0] next_bptr;
  logic [NUM_CH-1:0] next_tc_flag;
  dsa_io_rsp_t next_rsp;
  logic [31:0] next_addr32;

  logic [4:0] dec_res;
  logic [1:0] port_kind;
  logic [2:0] port_ch;
  logic port_ctl;
  logic [NUM_CH-1:0] req_live;
  logic [NUM_CH-1:0] cascade_mask;

  assign dec_res = port_decode(I_IO_REQ.addr);
  assign port_kind = dec_res[4:3];
  assign port_ch = dec_res[2:0];
  assign port_ctl = port_ch[2];
  assign cascade_mask = ~(NUM_CH'(1) << CASCADE_CH);
  // Any source of a request shows, and none is latched here.
  assign req_live = (hw_req_sync | I_REQ_SRC.sw_req | I_REQ_SRC.blk_tmo) & cascade_mask;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic acc;
    logic wr_ch;
    acc = 1'b0;
    wr_ch = 1'b0;
    next_cur = cur;
    next_base = base;
    next_bptr = bptr;
    next_tc_flag = tc_flag;
    next_rsp = '0;
    next_addr32 = {I_HIGH_PAGE, I_LOW_PAGE, cur[I_ACT_CH]};

    if (port_kind == PORT_STATUS && I_IO_REQ.rd) begin
      next_rsp.valid = 1'b1;
      next_rsp.data = {req_live[port_ch +: CH_PER_CTRL], tc_flag[port_ch +: CH_PER_CTRL]};
      next_tc_flag[port_ch +: CH_PER_CTRL] = '0;
    end

    acc = (port_kind == PORT_ADDR) && (I_IO_REQ.wr || I_IO_REQ.rd);
    if (acc) begin
      next_bptr[port_ctl] = ~bptr[port_ctl];
      if (I_IO_REQ.rd && !I_IO_REQ.wr) begin
        next_rsp.valid = 1'b1;
        // Only the current register is visible; base has no read path at all.
        next_rsp.data = bptr[port_ctl] ? cur[port_ch][15:8] : cur[port_ch][7:0];
      end
    end

    for (int c = 0; c < NUM_CTRL; c++) begin
      if (I_CLR_BPTR[c] || I_MASTER_CLR[c]) begin
        next_bptr[c] = 1'b0;
      end
    end

    for (int i = 0; i < NUM_CH; i++) begin
      wr_ch = acc && I_IO_REQ.wr && (port_ch == 3'(i));
      // A terminal count that lands on the clearing read is kept.
      if (I_CHAN_EV.tc[i] && (3'(i) != CASCADE_CH)) begin
        next_tc_flag[i] = 1'b1;
      end
      if (I_MASTER_CLR[i / CH_PER_CTRL]) begin
        next_cur[i] = ADDR_RST;
        next_base[i] = ADDR_RST;
        next_tc_flag[i] = 1'b0;
      end else if (wr_ch) begin
        if (bptr[port_ctl]) begin
          next_cur[i][15:8] = I_IO_REQ.wdata;
          next_base[i][15:8] = I_IO_REQ.wdata;
        end else begin
          next_cur[i][7:0] = I_IO_REQ.wdata;
          next_base[i][7:0] = I_IO_REQ.wdata;
        end
      end else begin
        if (I_CHAN_EV.sg_load[i]) begin
          next_base[i] = I_SG_ADDR;
        end
        if (I_CHAN_EV.autoinit[i] && (I_CHAN_EV.tc[i] || I_CHAN_EV.eop[i])) begin
          next_cur[i] = base[i];
        end else if (I_CHAN_EV.xfer[i]) begin
          next_cur[i] = I_CHAN_EV.dec[i] ? cur[i] - ADDR_STEP : cur[i] + ADDR_STEP;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge I_REF_CLK) begin
    hw_req_meta <= I_REQ_SRC.hw_req;
    hw_req_sync <= hw_req_meta;
    if (!I_RSTN) begin
      for (int i = 0; i < NUM_CH; i++) begin
        cur[i] <= ADDR_RST;
        base[i] <= ADDR_RST;
      end
      bptr <= '0;
      tc_flag <= STATUS_RST;
      rsp <= '0;
      addr32 <= '0;
    end else begin
      cur <= next_cur;
      base <= next_base;
      bptr <= next_bptr;
      tc_flag <= next_tc_flag;
      rsp <= next_rsp;
      addr32 <= next_addr32;
    end
  end

  assign O_IO_RSP = rsp;
  assign O_ADDR32 = addr32;
  assign O_ADDR24 = addr32[23:0];
  assign O_TC_FLAGS = tc_flag;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_RSTN);

  AST_STATUS_ANSWER: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_UPPER_STATUS
      |=> O_IO_RSP.valid && O_IO_RSP.data[3:0] == $past(tc_flag[7:4]))
    else $error("Upper status read did not answer with its flags.");

  AST_TC_SETS: assert property (I_CHAN_EV.tc[1] && !I_MASTER_CLR[0] |=> tc_flag[1] ##1 (tc_flag[1]
      || $past(I_IO_REQ.rd && I_IO_REQ.addr == OFS_LOWER_STATUS) || $past(I_MASTER_CLR[0])))
    else $error("Terminal count did not set its flag.");

  AST_TC_READ_CLEARS: assert property (I_IO_REQ.rd && I_IO_REQ.addr == OFS_LOWER_STATUS && I_CHAN_EV.tc[3:0] == 4'h0
      |=> tc_flag[3:0] == 4'h0)
    else $error("Status read did not clear the terminal-count flags.");

  AST_REQ_LIVE: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_LOWER_STATUS
      |=> O_IO_RSP.data[7:4] == $past(req_live[3:0]))
    else $error("Request status does not follow the live requests.");

  AST_CASCADE_QUIET: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_UPPER_STATUS
      |=> O_IO_RSP.data[REQ_LSB] == 1'b0 && O_IO_RSP.data[TC_LSB] == 1'b0)
    else $error("Cascade channel shows status.");

  AST_STEP_UP: assert property (I_CHAN_EV.xfer[1] && !I_CHAN_EV.dec[1] && !I_CHAN_EV.tc[1] && !I_CHAN_EV.eop[1]
      && !I_IO_REQ.wr && !I_MASTER_CLR[0] |=> cur[1] == $past(cur[1]) + ADDR_STEP)
    else $error("Current address did not step up after a transfer.");

  AST_BYTE_TOGGLE: assert property (I_IO_REQ.wr && I_IO_REQ.addr == OFS_CHAN_ADDR[5] && !I_CLR_BPTR[1] && !I_MASTER_CLR[1]
      |=> bptr[1] != $past(bptr[1]))
    else $error("Byte pointer did not toggle.");

  AST_BASE_FOLLOWS: assert property (I_IO_REQ.wr && I_IO_REQ.addr == OFS_CHAN_ADDR[2] && !I_MASTER_CLR[0]
      |=> $past(bptr[0]) ? (base[2][15:8] == $past(I_IO_REQ.wdata) && cur[2][15:8] == $past(I_IO_REQ.wdata))
        : (base[2][7:0] == $past(I_IO_REQ.wdata) && cur[2][7:0] == $past(I_IO_REQ.wdata)))
    else $error("Host write did not load base and current alike.");

  AST_AUTOINIT: assert property (I_CHAN_EV.autoinit[6] && I_CHAN_EV.tc[6] && !I_IO_REQ.wr && !I_MASTER_CLR[1]
      |=> cur[6] == $past(base[6]))
    else $error("Autoinitialize did not restore the current address.");

  AST_CLEAR: assert property (I_MASTER_CLR[1] |=> cur[7] == ADDR_RST && base[7] == ADDR_RST && tc_flag[7:4] == 4'h0)
    else $error("Master clear left address or flags standing.");

  AST_RESET: assert property (disable iff (1'b0) !I_RSTN |=> tc_flag == STATUS_RST && cur[0] == ADDR_RST)
    else $error("Reset left status or address standing.");

  // ----------------------------------------------------------------
  // Checks on answers, bytes and events
  // ----------------------------------------------------------------
  // Channels 0, 1 and 5 stand in for their controllers, since every lane but cascade channel 4 runs the same logic.

  AST_LOW_BYTE_READ: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_CHAN_ADDR[0]
      && !bptr[0] |=> O_IO_RSP.valid && O_IO_RSP.data == $past(cur[0][7:0]))
    else $error("Low byte read did not return the current low byte.");

  AST_HIGH_BYTE_READ: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_CHAN_ADDR[0]
      && bptr[0] |=> O_IO_RSP.valid && O_IO_RSP.data == $past(cur[0][15:8]))
    else $error("High byte read did not return the current high byte.");

  AST_PTR_CLEARED: assert property (I_CLR_BPTR[0]
      |=> bptr[0] == 1'b0)
    else $error("Byte pointer clear did not reach the low byte.");

  AST_PTR_PER_CTRL: assert property (I_IO_REQ.wr && I_IO_REQ.addr == OFS_CHAN_ADDR[1]
      && !I_CLR_BPTR[1] && !I_MASTER_CLR[1] |=> bptr[1] == $past(bptr[1]))
    else $error("Lower port access moved the upper byte pointer.");

  AST_HIGH_WRITE: assert property (I_IO_REQ.wr && I_IO_REQ.addr == OFS_CHAN_ADDR[0] && bptr[0]
      && !I_MASTER_CLR[0] |=> cur[0][15:8] == $past(I_IO_REQ.wdata) && base[0][15:8] == $past(I_IO_REQ.wdata))
    else $error("High byte write did not land in both registers.");

  AST_LOW_WRITE: assert property (I_IO_REQ.wr && I_IO_REQ.addr == OFS_CHAN_ADDR[0] && !bptr[0]
      && !I_MASTER_CLR[0] |=> cur[0][7:0] == $past(I_IO_REQ.wdata) && cur[0][15:8] == $past(cur[0][15:8]))
    else $error("Low byte write touched the wrong half.");

  AST_STEP_DOWN: assert property (I_CHAN_EV.xfer[1] && I_CHAN_EV.dec[1] && !I_CHAN_EV.tc[1]
      && !I_CHAN_EV.eop[1] && !I_IO_REQ.wr && !I_MASTER_CLR[0] |=> cur[1] == $past(cur[1]) - ADDR_STEP)
    else $error("Current address did not step down after a transfer.");

  AST_EOP_RELOAD: assert property (I_CHAN_EV.autoinit[1] && I_CHAN_EV.eop[1] && !I_IO_REQ.wr
      && !I_MASTER_CLR[0] |=> cur[1] == $past(base[1]))
    else $error("End of process did not restore the current address.");

  AST_ADDR_HOLD: assert property (!I_CHAN_EV.xfer[1] && !I_CHAN_EV.tc[1] && !I_CHAN_EV.eop[1]
      && !I_IO_REQ.wr && !I_MASTER_CLR[0] |=> cur[1] == $past(cur[1]))
    else $error("Current address moved without an event.");

  AST_SG_LOAD: assert property (I_CHAN_EV.sg_load[1] && !I_IO_REQ.wr
      && !I_MASTER_CLR[0] |=> base[1] == $past(I_SG_ADDR))
    else $error("Reserve buffer address did not reach the base register.");

  AST_ADDR32_JOIN: assert property (1'b1
      |=> O_ADDR32 == $past({I_HIGH_PAGE, I_LOW_PAGE, cur[I_ACT_CH]}))
    else $error("Full address is not the pages joined to the current address.");

  AST_ADDR24_JOIN: assert property (1'b1
      |=> O_ADDR24 == $past({I_LOW_PAGE, cur[I_ACT_CH]}))
    else $error("Legacy address is not the low page joined to the current address.");

  AST_REQ_LOWER: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_LOWER_STATUS
      |=> O_IO_RSP.data[7:4] == $past(hw_req_sync[3:0] | I_REQ_SRC.sw_req[3:0] | I_REQ_SRC.blk_tmo[3:0]))
    else $error("Lower request status misses a request source.");

  AST_REQ_UPPER: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_UPPER_STATUS
      |=> O_IO_RSP.data[7:5] == $past(hw_req_sync[7:5] | I_REQ_SRC.sw_req[7:5] | I_REQ_SRC.blk_tmo[7:5]))
    else $error("Upper request status does not map to its channels.");

  AST_LOWER_ANSWER: assert property (I_IO_REQ.rd && !I_IO_REQ.wr && I_IO_REQ.addr == OFS_LOWER_STATUS
      |=> O_IO_RSP.valid && O_IO_RSP.data[3:0] == $past(tc_flag[3:0]))
    else $error("Lower status read did not answer with its flags.");

  AST_STATUS_WRITE_IGNORED: assert property (I_IO_REQ.wr && !I_IO_REQ.rd && port_kind == PORT_STATUS
      && I_CHAN_EV.tc == '0 && I_MASTER_CLR == '0 |=> !O_IO_RSP.valid && tc_flag == $past(tc_flag))
    else $error("A status write had an effect.");

  AST_UNMAPPED_QUIET: assert property (I_IO_REQ.rd && port_kind == PORT_NONE
      |=> !O_IO_RSP.valid)
    else $error("An unmapped read was answered.");

  AST_NO_READ_NO_ANSWER: assert property (!I_IO_REQ.rd
      |=> !O_IO_RSP.valid)
    else $error("An answer came without a read.");

  AST_UPPER_READ_CLEARS: assert property (I_IO_REQ.rd && I_IO_REQ.addr == OFS_UPPER_STATUS
      && I_CHAN_EV.tc[7:4] == 4'h0 |=> tc_flag[7:4] == 4'h0)
    else $error("Upper status read did not clear its flags.");

  AST_UPPER_READ_KEEPS_LOWER: assert property (I_IO_REQ.rd && I_IO_REQ.addr == OFS_UPPER_STATUS
      && I_CHAN_EV.tc[3:0] == 4'h0 && !I_MASTER_CLR[0] |=> tc_flag[3:0] == $past(tc_flag[3:0]))
    else $error("Upper status read cleared the lower flags.");

  AST_TC_HOLD: assert property (!I_CHAN_EV.tc[1] && !I_IO_REQ.rd && !I_MASTER_CLR[0]
      |=> tc_flag[1] == $past(tc_flag[1]))
    else $error("Terminal-count flag changed without an event.");

  AST_CASCADE_TC: assert property (I_CHAN_EV.tc[CASCADE_CH]
      |=> !O_TC_FLAGS[CASCADE_CH])
    else $error("Cascade channel set a terminal-count flag.");

  AST_UPPER_TC: assert property (I_CHAN_EV.tc[5] && !I_MASTER_CLR[1]
      |=> O_TC_FLAGS[5])
    else $error("Upper channel terminal count did not set its flag.");

  AST_CLEAR_LOWER: assert property (I_MASTER_CLR[0]
      |=> cur[1] == ADDR_RST && base[1] == ADDR_RST && bptr[0] == 1'b0 && tc_flag[3:0] == 4'h0)
    else $error("Lower master clear left address, pointer or flags standing.");

  AST_RESET_REST: assert property (disable iff (1'b0) !I_RSTN
      |=> base[7] == ADDR_RST && bptr == 2'h0 && !O_IO_RSP.valid && O_ADDR32 == 32'h00000000)
    else $error("Reset left base, pointer or outputs standing.");

endmodule : dsa_status_addr

// ===== tb/dsa_host_model.sv
// Host model that issues byte accesses and byte pointer clears on the I/O port.
module dsa_host_model (
  input wire logic i_clk,
  input wire dsa_pkg::dsa_io_rsp_t i_rsp,
  output dsa_pkg::dsa_io_req_t o_req,
  output logic [1:0] o_clr_bptr
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsa_pkg::*;

  initial begin
    o_req = '0;
    o_clr_bptr = 2'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clk);
    o_req <= '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
    @(posedge i_clk);
    o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge i_clk);
    o_req <= '0;
    #1;
    v = i_rsp.valid;
    d = i_rsp.data;
  endtask : rd

  task automatic clr(input int c);
    @(posedge i_clk);
    o_clr_bptr <= 2'h1 << c;
    @(posedge i_clk);
    o_clr_bptr <= 2'h0;
  endtask : clr

  // The pointer is cleared first, otherwise a stray odd byte would swap the halves.
  task automatic wr16(input logic [7:0] a, input logic [15:0] v);
    clr(int'(a >= 8'hC0));
    wr(a, v[7:0]);
    wr(a, v[15:8]);
  endtask : wr16
endmodule : dsa_host_model

// ===== tb/dsa_status_addr_bench.sv
// Self-checking bench of the status and address block.
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", n, e, g); end end
module dsa_status_addr_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import dsa_pkg::*;
  logic clk, rstn, v;
  logic [1:0] clr, mclr;
  dsa_io_req_t req;
  dsa_io_rsp_t rsp;
  dsa_chan_ev_t ev;
  dsa_req_src_t rs;
  logic [15:0] sg, w, e;
  logic [7:0] xf, tcp, eo, sgl, dec, ai, lp, hp, d, tcf;
  logic [2:0] act;
  logic [23:0] a24;
  logic [31:0] a32;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  assign ev = '{xfer: xf, tc: tcp, eop: eo, dec: dec, autoinit: ai, sg_load: sgl};
  dsa_host_model i_host (.i_clk(clk), .i_rsp(rsp), .o_req(req), .o_clr_bptr(clr));
  dsa_status_addr i_dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_IO_REQ(req), .O_IO_RSP(rsp), .I_CLR_BPTR(clr),
    .I_MASTER_CLR(mclr), .I_CHAN_EV(ev), .I_REQ_SRC(rs), .I_SG_ADDR(sg), .I_ACT_CH(act), .I_LOW_PAGE(lp),
    .I_HIGH_PAGE(hp), .O_ADDR24(a24), .O_ADDR32(a32), .O_TC_FLAGS(tcf));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] val(input int i);
    return 16'h1230 + 16'(i) * 16'h0101;
  endfunction : val
  task automatic rd16(input int i, output logic [15:0] r);
    i_host.clr(i / 4);
    i_host.rd(OFS_CHAN_ADDR[i], v, r[7:0]);
    i_host.rd(OFS_CHAN_ADDR[i], v, r[15:8]);
  endtask : rd16
  task automatic st(input int c, input logic [7:0] x);
    i_host.rd(c ? OFS_UPPER_STATUS : OFS_LOWER_STATUS, v, d);
    `CHK("status", {1'b1, x}, {v, d})
  endtask : st
  task automatic pulse(input logic [7:0] x, input logic [7:0] t, input logic [7:0] o, input logic [7:0] s);
    @(posedge clk);
    {xf, tcp, eo, sgl} <= {x, t, o, s};
    @(posedge clk);
    {xf, tcp, eo, sgl} <= 32'h0;
    repeat (2) @(posedge clk);
    #1;
  endtask : pulse
  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // Clock, watchdog and sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The sequence needs well under a thousand cycles; this ceiling only catches a hang.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    rstn = 1'b0;
    {xf, tcp, eo, sgl, dec, ai} = 48'h0;
    rs = '0;
    sg = 16'hBEEF;
    act = 3'h1;
    lp = 8'h5A;
    hp = 8'hC3;
    mclr = 2'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    st(0, 8'h00);
    st(1, 8'h00);
    for (int i = 0; i < NUM_CH; i++) begin
      rd16(i, w);
      `CHK("addr reset", 16'h0000, w)
      i_host.wr16(OFS_CHAN_ADDR[i], val(i));
    end
    for (int i = 0; i < NUM_CH; i++) begin
      e = val(i);
      rd16(i, w);
      `CHK("addr", e, w)
      i_host.rd(OFS_CHAN_ADDR[i], v, d);
      `CHK("third byte", e[7:0], d)
    end
    e = val(1);
    `CHK("addr32", {hp, lp, e}, a32)
    `CHK("addr24", {lp, e}, a24)
    pulse(8'h02, 8'h00, 8'h00, 8'h00);
    `CHK("step up", e + 16'h0001, a32[15:0])
    @(posedge clk);
    {dec, ai} <= 16'h0202;
    pulse(8'h02, 8'h00, 8'h00, 8'h00);
    pulse(8'h02, 8'h00, 8'h00, 8'h00);
    `CHK("step down", e - 16'h0001, a32[15:0])
    pulse(8'h00, 8'h02, 8'h00, 8'h00);
    `CHK("reload", e, a32[15:0])
    `CHK("tc flags", 8'h02, tcf)
    st(0, 8'h02);
    st(0, 8'h00);
    pulse(8'h02, 8'h00, 8'h00, 8'h02);
    rd16(1, w);
    `CHK("cur after sg", e - 16'h0001, w)
    pulse(8'h00, 8'h00, 8'h02, 8'h00);
    `CHK("sg reload", 16'hBEEF, a32[15:0])
    pulse(8'h00, 8'h30, 8'h00, 8'h00);
    @(posedge clk);
    rs <= '{hw_req: 8'h04, sw_req: 8'h20, blk_tmo: 8'h90};
    repeat (4) @(posedge clk);
    st(0, 8'h40);
    st(1, 8'hA2);
    @(posedge clk);
    rs <= '0;
    repeat (4) @(posedge clk);
    st(0, 8'h00);
    st(1, 8'h00);
    @(posedge clk);
    mclr <= 2'h1;
    @(posedge clk);
    mclr <= 2'h0;
    rd16(1, w);
    `CHK("master clear", 16'h0000, w)
    e = val(5);
    rd16(5, w);
    `CHK("other ctrl kept", e, w)
    i_host.rd(8'h10, v, d);
    `CHK("unmapped valid", 1'b0, v)
    i_host.wr(OFS_LOWER_STATUS, 8'hFF);
    st(0, 8'h00);
    @(posedge clk);
    {act, ai} <= {3'h6, 8'h42};
    e = val(6) + 16'h0001;
    pulse(8'h40, 8'h00, 8'h00, 8'h00);
    `CHK("ch6 step", e, a32[15:0])
    pulse(8'h00, 8'h40, 8'h00, 8'h00);
    `CHK("ch6 reload", val(6), a32[15:0])
    `CHK("ch6 flag", 8'h40, tcf)
    @(posedge clk);
    mclr <= 2'h2;
    @(posedge clk);
    mclr <= 2'h0;
    #1;
    `CHK("flags cleared", 8'h00, tcf)
    st(1, 8'h00);
    rd16(6, w);
    `CHK("upper clear", 16'h0000, w)
    end_sim();
  end
endmodule : dsa_status_addr_bench
